// >>> core/vap_top.sv
// valve actuator position command logic with register access
// Operation
// - two-position: A request held 20 ms moves to A
// - two-position: qualified B request moves to B
// - release of a request never starts motion, except remote home, which acts on release
// - a request is asserted when driven low
// - A output high at A, B high at B
// - multiposition: qualified step advances one, set direction
// - one action per assertion; release before next
// - multiposition: home rotates to position 1, set direction
// - home output low at position 1, else high
// - motor-run output low while moving, else high
// - request during move retargets to the new position
// - two-position: remote up goes to B
// - two-position: remote down goes to A
// - multiposition: remote up advances one position
// - multiposition: remote down goes back one
// - two-position: remote home goes to A
// - multiposition: remote home goes to position 1
// - remote home held 5 s enters configuration
// - remote up in configuration leaves configuration
// - position counter spans positions 1 to 32
`timescale 1ns/1ps
module vap_top #(
  parameter int TICK_CYCLES = vap_pkg::TICK_CYC,
  parameter int QUAL_TICKS = vap_pkg::QUAL_TICKS,
  parameter int HOLD_TICKS = vap_pkg::HOLD_TICKS,
  parameter int STEP_DIV = vap_pkg::STEP_DIV,
  parameter int STEPS_PER_POS = vap_pkg::STEPS_PER_POS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_a_home_n_i,
  input wire logic req_b_step_n_i,
  input wire logic btn_up_n_i,
  input wire logic btn_down_n_i,
  input wire logic btn_home_n_i,
  output logic fb_a_home_o,
  output logic fb_b_run_o,
  output logic motor_step_o,
  output logic motor_dir_o,
  output logic cfg_mode_o,
  output logic [4:0] position_o,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int HW = $clog2(HOLD_TICKS + 1);
  if (TICK_CYCLES < 2 || HOLD_TICKS < 2) begin : g_bad
    $error("tick divider and hold count must be at least two");
  end

  // 1 ms enable from the system clock
  // free running, so the first tick of a request may be partial
  logic [TW-1:0] tick_cnt_reg;
  logic tick_reg;
  wire tick_end = tick_cnt_reg == TW'(TICK_CYCLES - 1);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_end ? '0 : tick_cnt_reg + 1'b1;
      tick_reg <= tick_end;
    end
  end

  // low-active pins are qualified in one place
  wire [4:0] raw_n = {btn_home_n_i, btn_down_n_i, btn_up_n_i,
                      req_b_step_n_i, req_a_home_n_i};
  logic [4:0] lvl;
  logic [4:0] prs;
  vap_qual #(
    .N(vap_pkg::N_IN),
    .QUAL(QUAL_TICKS)
  ) u_qual (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick_reg),
    .in_n_i(raw_n),
    .level_o(lvl),
    .press_o(prs)
  );

  // control register
  logic ctrl_multi_reg;
  logic ctrl_rev_reg;
  logic [4:0] ctrl_npos_reg;
  wire multi = ctrl_multi_reg;
  // two-position travel only ever spans A and B
  wire [4:0] last = multi ? ctrl_npos_reg : vap_pkg::POS_B;

  // remote home: action on release, or configuration after long hold
  logic [HW-1:0] hold_reg;
  logic home_prev_reg;
  logic cfg_reg;
  wire hold_full = hold_reg == HW'(HOLD_TICKS);
  wire home_rel = home_prev_reg & ~lvl[vap_pkg::IN_HOME];
  wire cfg_enter = lvl[vap_pkg::IN_HOME] & ~cfg_reg & tick_reg
                   & (hold_reg == HW'(HOLD_TICKS - 1));
  wire cfg_exit = cfg_reg & prs[vap_pkg::IN_UP];
  // hold count saturates, so a very long hold never turns back into an action
  wire home_act = home_rel & ~hold_full & ~cfg_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_reg <= '0;
      home_prev_reg <= 1'b0;
    end else begin
      home_prev_reg <= lvl[vap_pkg::IN_HOME];
      if (!lvl[vap_pkg::IN_HOME]) begin
        hold_reg <= '0;
      end else if (tick_reg && !hold_full) begin
        hold_reg <= hold_reg + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg <= 1'b0;
    end else if (cfg_enter) begin
      cfg_reg <= 1'b1;
    end else if (cfg_exit) begin
      cfg_reg <= 1'b0;
    end
  end

  // position tracking
  // the last position wraps to position 1 going forward, and position 1 to the last going back
  function automatic logic [4:0] fwd(input logic [4:0] p, input logic [4:0] l);
    fwd = (p >= l) ? 5'h00 : p + 5'h01;
  endfunction
  function automatic logic [4:0] bwd(input logic [4:0] p, input logic [4:0] l);
    bwd = (p == 5'h00) ? l : p - 5'h01;
  endfunction

  vap_pkg::vap_state_e state_reg;
  vap_pkg::vap_state_e state_next;
  logic [4:0] pos_reg;
  logic [4:0] tgt_reg;
  logic mdir_reg;
  logic pos_done;
  wire moving = state_reg == vap_pkg::VAP_MOVE;
  // a retarget during motion is counted from the pending target
  wire [4:0] base = moving ? tgt_reg : pos_reg;
  wire rev = ctrl_rev_reg;
  // buttons are ignored for positioning while configuring
  wire up_cmd = prs[vap_pkg::IN_UP] & ~cfg_reg;
  wire dn_cmd = prs[vap_pkg::IN_DOWN] & ~cfg_reg;

  wire go_a = prs[vap_pkg::IN_PIN4] | dn_cmd | home_act;
  wire go_b = prs[vap_pkg::IN_PIN6] | up_cmd;
  wire m_home = prs[vap_pkg::IN_PIN4] | home_act;
  wire m_step = prs[vap_pkg::IN_PIN6];
  wire [4:0] step_tgt = rev ? bwd(base, last) : fwd(base, last);

  // press pulses, plus the remote home release; no other release loads a target
  wire load = multi ? (m_home | m_step | up_cmd | dn_cmd)
                    : (go_a | go_b);
  wire [4:0] tgt_2p = go_a ? vap_pkg::POS_A : vap_pkg::POS_B;
  wire [4:0] tgt_mp = m_home ? 5'h00 :
                      m_step ? step_tgt :
                      up_cmd ? fwd(base, last) :
                      bwd(base, last);
  // up outranks down, so a press of both must still travel forward
  wire dir_mp = (m_home | m_step) ? rev : ~up_cmd;
  wire [4:0] tgt_new = multi ? tgt_mp : tgt_2p;
  wire dir_new = multi ? dir_mp : go_a;
  wire [4:0] tgt_eff = load ? tgt_new : tgt_reg;
  wire dir_eff = load ? dir_new : mdir_reg;
  wire [4:0] pos_adv = !pos_done ? pos_reg :
                       mdir_reg ? bwd(pos_reg, last) : fwd(pos_reg, last);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      vap_pkg::VAP_IDLE: begin
        if (load && tgt_new != pos_reg) begin
          state_next = vap_pkg::VAP_MOVE;
        end
      end
      vap_pkg::VAP_MOVE: begin
        if (tgt_eff == pos_adv) begin
          state_next = vap_pkg::VAP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= vap_pkg::VAP_IDLE;
      pos_reg <= vap_pkg::POS_A;
      tgt_reg <= vap_pkg::POS_A;
      mdir_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pos_reg <= pos_adv;
      tgt_reg <= tgt_eff;
      mdir_reg <= dir_eff;
    end
  end

  vap_motor #(
    .STEP_DIV(STEP_DIV),
    .STEPS_PER_POS(STEPS_PER_POS)
  ) u_motor (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(moving),
    .dir_i(mdir_reg),
    .step_o(motor_step_o),
    .dir_o(motor_dir_o),
    .pos_done_o(pos_done)
  );

  // discrete feedback, pins 1 and 3
  // two-position flags wait for idle, so a move away drops them at once
  wire at_a = ~moving & (pos_reg == vap_pkg::POS_A);
  wire at_b = ~moving & (pos_reg == vap_pkg::POS_B);
  wire at_home = pos_reg == 5'h00;
  wire pin1_next = multi ? ~at_home : at_a;
  wire pin3_next = multi ? ~moving : at_b;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fb_a_home_o <= 1'b0;
      fb_b_run_o <= 1'b0;
      cfg_mode_o <= 1'b0;
      position_o <= 5'h00;
    end else begin
      fb_a_home_o <= pin1_next;
      fb_b_run_o <= pin3_next;
      cfg_mode_o <= cfg_reg;
      position_o <= pos_reg;
    end
  end

  // register slave: write takes address and data together
  logic [3:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_do_reg;
  // one write in flight: no new take until the response has gone
  wire aw_take = s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_awready_o
                 & ~wr_do_reg & ~s_axi_bvalid_o;
  wire wr_ctrl = wr_do_reg & (waddr_reg == vap_pkg::ADDR_CTRL);
  wire wr_map = (waddr_reg == vap_pkg::ADDR_CTRL)
                | (waddr_reg == vap_pkg::ADDR_STAT)
                | (waddr_reg == vap_pkg::ADDR_TGT);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      wr_do_reg <= 1'b0;
      waddr_reg <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      s_axi_awready_o <= aw_take;
      s_axi_wready_o <= aw_take;
      wr_do_reg <= aw_take;
      if (aw_take) begin
        waddr_reg <= s_axi_awaddr_i;
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= vap_pkg::RESP_OKAY;
    end else if (wr_do_reg) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_map ? vap_pkg::RESP_OKAY : vap_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_multi_reg <= vap_pkg::CTRL_MULTI_RST;
      ctrl_rev_reg <= vap_pkg::CTRL_REV_RST;
      ctrl_npos_reg <= vap_pkg::CTRL_NPOS_RST;
    end else if (wr_ctrl) begin
      if (wstrb_reg[0]) begin
        ctrl_multi_reg <= wdata_reg[vap_pkg::CTRL_MULTI_BIT];
        ctrl_rev_reg <= wdata_reg[vap_pkg::CTRL_REV_BIT];
      end
      if (wstrb_reg[1]) begin
        ctrl_npos_reg <= wdata_reg[vap_pkg::CTRL_NPOS_LSB +: 5];
      end
    end
  end

  // read channel
  // read data are captured with the address and held until taken
  wire ar_take = s_axi_arvalid_i & ~s_axi_arready_o & ~s_axi_rvalid_o;
  wire [31:0] ctrl_val = {19'h0, ctrl_npos_reg, 6'h00, ctrl_rev_reg, ctrl_multi_reg};
  wire [31:0] stat_val = {20'h0, at_b, at_a, cfg_reg, moving, 3'h0, pos_reg};
  wire [31:0] tgt_val = {27'h0, tgt_reg};
  wire rd_ctrl = s_axi_araddr_i == vap_pkg::ADDR_CTRL;
  wire rd_stat = s_axi_araddr_i == vap_pkg::ADDR_STAT;
  wire rd_tgt = s_axi_araddr_i == vap_pkg::ADDR_TGT;
  wire rd_map = rd_ctrl | rd_stat | rd_tgt;
  wire [31:0] rd_val = rd_ctrl ? ctrl_val :
                       rd_stat ? stat_val :
                       rd_tgt ? tgt_val : 32'h0000_0000;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= vap_pkg::RESP_OKAY;
    end else begin
      s_axi_arready_o <= ar_take;
      if (ar_take) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_val;
        s_axi_rresp_o <= rd_map ? vap_pkg::RESP_OKAY : vap_pkg::RESP_SLVERR;
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end
endmodule

// >>> core/vap_pkg.sv
// shared constants for the valve actuator position command block
package vap_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int QUAL_MS = 20;
  localparam int QUAL_TICKS = (QUAL_MS * 1000 + TICK_US - 1) / TICK_US;
  localparam int HOLD_S = 5;
  localparam int HOLD_TICKS = HOLD_S * 1_000_000 / TICK_US;
  localparam int MAX_POS = 32;
  localparam int POS_W = 5;
  localparam int STEP_DIV = 2500;
  localparam int STEPS_PER_POS = 50;
  localparam int N_IN = 5;
  localparam int IN_PIN4 = 0;
  localparam int IN_PIN6 = 1;
  localparam int IN_UP = 2;
  localparam int IN_DOWN = 3;
  localparam int IN_HOME = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_TGT = 4'h8;
  localparam int CTRL_MULTI_BIT = 0;
  localparam int CTRL_REV_BIT = 1;
  localparam int CTRL_NPOS_LSB = 8;
  localparam logic CTRL_MULTI_RST = 1'b0;
  localparam logic CTRL_REV_RST = 1'b0;
  localparam logic [4:0] CTRL_NPOS_RST = 5'h09;
  localparam int STAT_RUN_BIT = 8;
  localparam int STAT_CFG_BIT = 9;
  localparam int STAT_ATA_BIT = 10;
  localparam int STAT_ATB_BIT = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [4:0] POS_A = 5'h00;
  localparam logic [4:0] POS_B = 5'h01;
  typedef enum logic {
    VAP_IDLE = 1'b0,
    VAP_MOVE = 1'b1
  } vap_state_e;
endpackage

// >>> core/vap_qual.sv
// input synchroniser and assertion-time qualifier, one lane per input
`timescale 1ns/1ps
module vap_qual #(
  parameter int N = 5,
  parameter int QUAL = 20
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic [N-1:0] in_n_i,
  output logic [N-1:0] level_o,
  output logic [N-1:0] press_o
);
  localparam int CW = $clog2(QUAL + 1) + 1;
  if (QUAL < 1) begin : g_bad
    $error("QUAL must be at least one tick");
  end
  genvar g;
  for (g = 0; g < N; g++) begin : g_lane
    logic s1_reg;
    logic s2_reg;
    logic lvl_reg;
    logic prs_reg;
    logic [CW-1:0] cnt_reg;
    wire asserted = ~s2_reg;
    // one extra tick so a partial first tick never shortens the minimum
    wire done = tick_i & ~lvl_reg & (cnt_reg == CW'(QUAL));
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        s1_reg <= 1'b1;
        s2_reg <= 1'b1;
      end else begin
        s1_reg <= in_n_i[g];
        s2_reg <= s1_reg;
      end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cnt_reg <= '0;
        lvl_reg <= 1'b0;
        prs_reg <= 1'b0;
      end else if (!asserted) begin
        cnt_reg <= '0;
        lvl_reg <= 1'b0;
        prs_reg <= 1'b0;
      end else begin
        if (tick_i && !lvl_reg) begin
          cnt_reg <= cnt_reg + 1'b1;
        end
        lvl_reg <= lvl_reg | done;
        prs_reg <= done;
      end
    end
    assign level_o[g] = lvl_reg;
    assign press_o[g] = prs_reg;
  end
endmodule

// >>> core/vap_motor.sv
// stepper pulse generator; reports each whole position travelled
`timescale 1ns/1ps
module vap_motor #(
  parameter int STEP_DIV = 2500,
  parameter int STEPS_PER_POS = 50
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic dir_i,
  output logic step_o,
  output logic dir_o,
  output logic pos_done_o
);
  localparam int DW = $clog2(STEP_DIV);
  localparam int SW = $clog2(STEPS_PER_POS);
  if (STEP_DIV < 2 || STEPS_PER_POS < 2) begin : g_bad
    $error("motor divider and step count must be at least two");
  end
  logic [DW-1:0] div_reg;
  logic [SW-1:0] stp_reg;
  wire div_end = div_reg == DW'(STEP_DIV - 1);
  wire stp_end = stp_reg == SW'(STEPS_PER_POS - 1);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= '0;
      stp_reg <= '0;
      step_o <= 1'b0;
      dir_o <= 1'b0;
      pos_done_o <= 1'b0;
    end else begin
      dir_o <= dir_i;
      step_o <= en_i & div_end;
      pos_done_o <= en_i & div_end & stp_end;
      if (!en_i) begin
        div_reg <= '0;
        stp_reg <= '0;
      end else if (div_end) begin
        div_reg <= '0;
        stp_reg <= stp_end ? '0 : stp_reg + 1'b1;
      end else begin
        div_reg <= div_reg + 1'b1;
      end
    end
  end
endmodule

// >>> verif/vap_top_asserts.sv
// concurrent checks on the actuator command block ports
`timescale 1ns/1ps
module vap_top_asserts (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic fb_a_home_o,
  input wire logic fb_b_run_o,
  input wire logic motor_step_o,
  input wire logic [4:0] position_o,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  logic multi_q;
  // shadow of the mode bit; feedback meaning flips with it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      multi_q <= 1'b0;
    end else if (s_axi_awready_o && s_axi_wready_o && s_axi_awaddr_i == vap_pkg::ADDR_CTRL && s_axi_wstrb_i[0]) begin
      multi_q <= s_axi_wdata_i[vap_pkg::CTRL_MULTI_BIT];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // three cycles of one mode so registered feedback has settled
  sequence s_two;
    !multi_q ##1 !multi_q ##1 !multi_q;
  endsequence
  sequence s_multi;
    multi_q ##1 multi_q ##1 multi_q;
  endsequence
  sequence s_rd(logic [3:0] a);
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == a;
  endsequence
  property p_at_a;
    s_two ##0 fb_a_home_o |-> position_o == vap_pkg::POS_A;
  endproperty
  property p_at_b;
    s_two ##0 fb_b_run_o |-> position_o == vap_pkg::POS_B;
  endproperty
  property p_home;
    s_multi ##0 $stable(position_o) |-> fb_a_home_o == (position_o != vap_pkg::POS_A);
  endproperty
  a_two_at_a: assert property (p_at_a) else $error("A feedback high away from A");
  a_two_at_b: assert property (p_at_b) else $error("B feedback high away from B");
  a_multi_home: assert property (p_home) else $error("home feedback wrong");
  a_multi_run: assert property (s_multi ##0 motor_step_o |-> !fb_b_run_o) else $error("run flag high while stepping");
  a_rd_unmapped: assert property (s_rd(4'hC) |-> s_axi_rvalid_o && s_axi_rresp_o == vap_pkg::RESP_SLVERR
    && s_axi_rdata_o == 32'h0000_0000) else $error("unmapped read not refused");
  a_rd_stat_ok: assert property (s_rd(vap_pkg::ADDR_STAT) |-> s_axi_rresp_o == vap_pkg::RESP_OKAY)
    else $error("status read not okay");
  a_wr_resp: assert property (s_axi_awready_o && s_axi_wready_o |=> s_axi_bvalid_o) else $error("no write response");
  a_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o) else $error("bvalid dropped");
  a_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data not held");
endmodule
bind vap_top vap_top_asserts u_asserts (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .fb_a_home_o(fb_a_home_o), .fb_b_run_o(fb_b_run_o),
  .motor_step_o(motor_step_o), .position_o(position_o), .s_axi_awaddr_i(s_axi_awaddr_i),
  .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i)
);

// >>> verif/vap_contacts.sv
// switch contact model for the five request lines
`timescale 1ns/1ps
module vap_contacts (
  input wire logic clk_i,
  input wire logic [4:0] hold_i,
  output logic [4:0] line_n_o
);
  logic [4:0] first;
  // only one contact closes at a time; others stay open
  assign first = hold_i & (~hold_i + 5'h01);
  initial line_n_o = 5'h1F;
  // an open contact reads at the pull-up level
  always @(posedge clk_i) begin
    line_n_o <= ~first;
  end
endmodule

// >>> verif/tb.sv
// self-checking bench for the actuator command block
`timescale 1ns/1ps
module tb;
  localparam int SPP = 8;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] hold = 5'h00;
  logic [4:0] sw_n;
  logic fb_a, fb_b, mstep, cfg, mdir;
  logic [4:0] pos;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int n_errors = 0;
  int checks = 0;
  int n_steps = 0;
  vap_contacts u_sw (.clk_i(clk_i), .hold_i(hold), .line_n_o(sw_n));
  vap_top #(.TICK_CYCLES(4), .QUAL_TICKS(2), .HOLD_TICKS(10), .STEP_DIV(2), .STEPS_PER_POS(SPP)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .req_a_home_n_i(sw_n[0]), .req_b_step_n_i(sw_n[1]),
    .btn_up_n_i(sw_n[2]), .btn_down_n_i(sw_n[3]), .btn_home_n_i(sw_n[4]), .fb_a_home_o(fb_a),
    .fb_b_run_o(fb_b), .motor_step_o(mstep), .motor_dir_o(mdir), .cfg_mode_o(cfg), .position_o(pos),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (mstep === 1'b1) n_steps++;
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk_i); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk_i); while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp("bresp", er, bresp);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk_i);
    rready <= 1'b0;
    cmp("rdata", ed, rdata);
    cmp("rresp", er, rresp);
  endtask
  // close one contact for hc cycles, let any move finish, judge travel
  task go(input int idx, input int hc, input logic [4:0] ep, input int es);
    int s0;
    @(posedge clk_i);
    s0 = n_steps;
    hold[idx] <= 1'b1;
    repeat (hc) @(posedge clk_i);
    hold[idx] <= 1'b0;
    repeat (200) @(posedge clk_i);
    cmp("position", ep, pos);
    if (es >= 0) cmp("steps", es, n_steps - s0);
  endtask
  task t_regs;
    rd(vap_pkg::ADDR_CTRL, 32'h0000_0900, vap_pkg::RESP_OKAY);
    wr(vap_pkg::ADDR_STAT, 32'hFFFF_FFFF, vap_pkg::RESP_OKAY);
    rd(vap_pkg::ADDR_STAT, 32'h0000_0400, vap_pkg::RESP_OKAY);
    wr(4'hC, 32'h0000_0001, vap_pkg::RESP_SLVERR);
    rd(4'hC, 32'h0000_0000, vap_pkg::RESP_SLVERR);
  endtask
  task t_two_pos;
    go(vap_pkg::IN_PIN6, 30, vap_pkg::POS_B, SPP);
    cmp("fb_b", 1, fb_b);
    cmp("motor_dir", 0, mdir);
    cmp("fb_a", 0, fb_a);
    go(vap_pkg::IN_PIN4, 5, vap_pkg::POS_B, 0);
    go(vap_pkg::IN_PIN4, 30, vap_pkg::POS_A, SPP);
    cmp("fb_a", 1, fb_a);
    cmp("motor_dir", 1, mdir);
    go(vap_pkg::IN_DOWN, 30, vap_pkg::POS_A, 0);
    go(vap_pkg::IN_HOME, 30, vap_pkg::POS_A, 0);
    go(vap_pkg::IN_UP, 30, vap_pkg::POS_B, SPP);
    go(vap_pkg::IN_UP, 30, vap_pkg::POS_B, 0);
    go(vap_pkg::IN_DOWN, 30, vap_pkg::POS_A, SPP);
    go(vap_pkg::IN_UP, 30, vap_pkg::POS_B, SPP);
    go(vap_pkg::IN_HOME, 30, vap_pkg::POS_A, SPP);
  endtask
  task t_multi;
    wr(vap_pkg::ADDR_CTRL, 32'h0000_0901, vap_pkg::RESP_OKAY);
    go(vap_pkg::IN_PIN6, 80, 5'h01, SPP);
    go(vap_pkg::IN_UP, 30, 5'h02, SPP);
    go(vap_pkg::IN_DOWN, 30, 5'h01, SPP);
    cmp("fb_home", 1, fb_a);
    cmp("fb_run", 1, fb_b);
    go(vap_pkg::IN_PIN4, 30, 5'h00, 9 * SPP);
    cmp("fb_home", 0, fb_a);
    go(vap_pkg::IN_UP, 30, 5'h01, SPP);
    go(vap_pkg::IN_HOME, 30, 5'h00, -1);
    go(vap_pkg::IN_PIN6, 30, 5'h01, SPP);
    // long home move, then one step lands while it is still running; no request repeats mid-move
    hold[vap_pkg::IN_PIN4] <= 1'b1;
    repeat (40) @(posedge clk_i);
    hold[vap_pkg::IN_PIN4] <= 1'b0;
    go(vap_pkg::IN_PIN6, 30, 5'h01, -1);
    wr(vap_pkg::ADDR_CTRL, 32'h0000_1F01, vap_pkg::RESP_OKAY);
    go(vap_pkg::IN_DOWN, 30, 5'h00, SPP);
    go(vap_pkg::IN_DOWN, 30, 5'h1F, SPP);
    rd(vap_pkg::ADDR_TGT, 32'h0000_001F, vap_pkg::RESP_OKAY);
    // reversed rotation: a step goes back one position
    wr(vap_pkg::ADDR_CTRL, 32'h0000_1F03, vap_pkg::RESP_OKAY);
    go(vap_pkg::IN_PIN6, 30, 5'h1E, SPP);
    cmp("motor_dir", 1, mdir);
    wr(vap_pkg::ADDR_CTRL, 32'h0000_1F01, vap_pkg::RESP_OKAY);
    go(vap_pkg::IN_PIN6, 30, 5'h1F, SPP);
    cmp("motor_dir", 0, mdir);
  endtask
  task t_cfg;
    go(vap_pkg::IN_HOME, 60, 5'h1F, 0);
    cmp("cfg", 1, cfg);
    go(vap_pkg::IN_DOWN, 30, 5'h1F, 0);
    go(vap_pkg::IN_UP, 30, 5'h1F, 0);
    cmp("cfg", 0, cfg);
    go(vap_pkg::IN_PIN4, 30, 5'h00, SPP);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_two_pos;
    t_multi;
    t_cfg;
    end_of_test;
  end
  // about 27 presses of some 240 cycles each; allow more than twice that
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    end_of_test;
  end
endmodule
